// File: design/dcsp_regs.sv
// size and progress-pointer registers of one dma channel, with its
// block, cell, half-way and done events and a masked interrupt
// assumes the transfer engine reports bytes moved per cycle on the same
// clock, and a register master that never waits
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module dcsp_regs
  import dcsp_pkg::*;
(
  // clock, reset and freeze
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [dcsp_pkg::DCSP_AW-1:0] reg_addr_i,
  input wire logic [dcsp_pkg::DCSP_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [dcsp_pkg::DCSP_DW-1:0] reg_rdata_o,
  // transfer engine reports
  input wire logic [dcsp_pkg::DCSP_SW-1:0] src_bytes_i,
  input wire logic [dcsp_pkg::DCSP_SW-1:0] dst_bytes_i,
  input wire logic pattern_mode_i,
  input wire logic pattern_match_i,
  // events and interrupt
  output logic block_done_o,
  output logic cell_done_o,
  output logic irq_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] src_len;
    logic [15:0] dst_len;
    logic [15:0] cell_len;
    logic [15:0] src_prog;
    logic [15:0] dst_prog;
    // counters are 17 bits wide so a full 64 KiB length fits
    logic [16:0] blk_cnt;
    logic [16:0] cell_cnt;
    logic [3:0] sts;
    logic [3:0] msk;
    logic [31:0] rdata;
    logic irq;
    logic blk_pulse;
    logic cell_pulse;
  } dcsp_state_t;

  dcsp_state_t st_q;
  dcsp_state_t st_d;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic [16:0] s_sum;
    logic [16:0] d_sum;
    logic [16:0] b_sum;
    logic [16:0] c_sum;
    logic [16:0] blk_lim;
    logic [16:0] cell_lim;
    logic [15:0] s_half;
    logic [2:0] b_step;
    logic [3:0] ev;
    logic [3:0] clr;
    logic pat_hit;
    s_sum = 17'h0_0000;
    d_sum = 17'h0_0000;
    b_sum = 17'h0_0000;
    c_sum = 17'h0_0000;
    blk_lim = 17'h0_0000;
    cell_lim = 17'h0_0000;
    s_half = 16'h0000;
    b_step = 3'h0;
    ev = DCSP_RST_EVT;
    clr = DCSP_RST_EVT;
    pat_hit = pattern_mode_i & pattern_match_i;
    // start from the held state; only what changes is written below
    st_d = st_q;
    st_d.rdata = DCSP_RST_RDATA;
    st_d.blk_pulse = 1'b0;
    st_d.cell_pulse = 1'b0;

    // ==========================================================
    // source progress
    s_half = {1'b0, st_q.src_len[15:1]};
    s_sum = {1'b0, st_q.src_prog} + {14'h0000, src_bytes_i};

    // a pattern match wins over bytes reported in the same cycle
    if (pat_hit)
    begin
      st_d.src_prog = DCSP_RST_PROG;
    end
    else if (src_bytes_i != 3'h0)
    begin
      if (s_sum == {1'b0, s_half})
      begin
        ev[DCSP_EV_SRC_HALF] = 1'b1;
      end

      // a zero length lets the pointer run the full 16-bit range
      if ((st_q.src_len != 16'h0000) && (s_sum >= {1'b0, st_q.src_len}))
      begin
        st_d.src_prog = DCSP_RST_PROG;
      end
      else
      begin
        st_d.src_prog = s_sum[15:0];
      end
    end

    // ==========================================================
    // destination progress
    d_sum = {1'b0, st_q.dst_prog} + {14'h0000, dst_bytes_i};

    // a zero length leaves the pointer free over the full 16-bit range
    if (dst_bytes_i != 3'h0)
    begin
      if ((st_q.dst_len != 16'h0000) && (d_sum == {1'b0, st_q.dst_len}))
      begin
        ev[DCSP_EV_DST_DONE] = 1'b1;
      end

      // overshoot past the length is dropped, not carried
      if ((st_q.dst_len != 16'h0000) && (d_sum >= {1'b0, st_q.dst_len}))
      begin
        st_d.dst_prog = DCSP_RST_PROG;
      end
      else
      begin
        st_d.dst_prog = d_sum[15:0];
      end
    end

    // ==========================================================
    // block: the busier side sets the pace
    if (src_bytes_i > dst_bytes_i)
    begin
      b_step = src_bytes_i;
    end
    else
    begin
      b_step = dst_bytes_i;
    end

    if (st_q.src_len > st_q.dst_len)
    begin
      blk_lim = {1'b0, st_q.src_len};
    end
    else
    begin
      blk_lim = {1'b0, st_q.dst_len};
    end

    // both lengths zero: treat the block as a full 64 KiB
    if (blk_lim == 17'h0_0000)
    begin
      blk_lim = DCSP_FULL_LEN;
    end
    b_sum = st_q.blk_cnt + {14'h0000, b_step};

    // a pattern match closes the block early; any carried count is dropped
    if (pat_hit)
    begin
      ev[DCSP_EV_BLOCK] = 1'b1;
      st_d.blk_cnt = DCSP_RST_CNT;
    end
    else if (b_step != 3'h0)
    begin
      if (b_sum >= blk_lim)
      begin
        ev[DCSP_EV_BLOCK] = 1'b1;
        st_d.blk_cnt = DCSP_RST_CNT;
      end
      else
      begin
        st_d.blk_cnt = b_sum;
      end
    end

    // ==========================================================
    // cell: counted on bytes written
    // a pattern match restarts the cell count as well
    if (st_q.cell_len == 16'h0000)
    begin
      cell_lim = DCSP_FULL_LEN;
    end
    else
    begin
      cell_lim = {1'b0, st_q.cell_len};
    end

    c_sum = st_q.cell_cnt + {14'h0000, dst_bytes_i};
    if (pat_hit)
    begin
      st_d.cell_cnt = DCSP_RST_CNT;
    end
    else if (dst_bytes_i != 3'h0)
    begin
      if (c_sum >= cell_lim)
      begin
        ev[DCSP_EV_CELL] = 1'b1;
        st_d.cell_cnt = DCSP_RST_CNT;
      end
      else
      begin
        st_d.cell_cnt = c_sum;
      end
    end

    // pulses leave the flops one cycle after the step that caused them
    st_d.blk_pulse = ev[DCSP_EV_BLOCK];
    st_d.cell_pulse = ev[DCSP_EV_CELL];

    // ==========================================================
    // register writes; progress registers ignore writes
    // writing a length does not move a pointer, so a shrink can leave
    // a pointer beyond the new length until it next advances
    if (reg_we_i)
    begin
      case (reg_addr_i)
        DCSP_OFF_SRC_LEN:
        begin
          st_d.src_len = reg_wdata_i[15:0];
        end
        DCSP_OFF_DST_LEN:
        begin
          st_d.dst_len = reg_wdata_i[15:0];
        end
        DCSP_OFF_CELL_LEN:
        begin
          st_d.cell_len = reg_wdata_i[15:0];
        end
        DCSP_OFF_EVT_STS:
        begin
          clr = reg_wdata_i[3:0];
        end
        DCSP_OFF_EVT_MSK:
        begin
          st_d.msk = reg_wdata_i[3:0];
        end
        default:
        begin
          clr = DCSP_RST_EVT;
        end
      endcase
    end

    // ==========================================================
    // status and interrupt
    // a new event beats a clear written in the same cycle
    st_d.sts = (st_q.sts & ~clr) | ev;
    // taken from the next state so irq rises with its status bit
    st_d.irq = |(st_d.sts & st_d.msk);

    // ==========================================================
    // register reads, answered one cycle later
    if (reg_re_i)
    begin
      case (reg_addr_i)
        DCSP_OFF_SRC_LEN:
        begin
          st_d.rdata = {16'h0000, st_q.src_len};
        end
        DCSP_OFF_DST_LEN:
        begin
          st_d.rdata = {16'h0000, st_q.dst_len};
        end
        DCSP_OFF_SRC_PROG:
        begin
          st_d.rdata = {16'h0000, st_q.src_prog};
        end
        DCSP_OFF_DST_PROG:
        begin
          st_d.rdata = {16'h0000, st_q.dst_prog};
        end
        DCSP_OFF_CELL_LEN:
        begin
          st_d.rdata = {16'h0000, st_q.cell_len};
        end
        DCSP_OFF_EVT_STS:
        begin
          st_d.rdata = {28'h000_0000, st_q.sts};
        end
        DCSP_OFF_EVT_MSK:
        begin
          st_d.rdata = {28'h000_0000, st_q.msk};
        end
        default:
        begin
          st_d.rdata = DCSP_RST_RDATA;
        end
      endcase
    end
  end

  // ==========================================================
  // state register; ce_i low freezes everything
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q.src_len <= DCSP_RST_LEN;
      st_q.dst_len <= DCSP_RST_LEN;
      st_q.cell_len <= DCSP_RST_LEN;
      st_q.src_prog <= DCSP_RST_PROG;
      st_q.dst_prog <= DCSP_RST_PROG;
      st_q.blk_cnt <= DCSP_RST_CNT;
      st_q.cell_cnt <= DCSP_RST_CNT;
      st_q.sts <= DCSP_RST_EVT;
      st_q.msk <= DCSP_RST_EVT;
      st_q.rdata <= DCSP_RST_RDATA;
      st_q.irq <= 1'b0;
      st_q.blk_pulse <= 1'b0;
      st_q.cell_pulse <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  // no logic after the flops, so the outputs never glitch
  assign reg_rdata_o = st_q.rdata;
  assign block_done_o = st_q.blk_pulse;
  assign cell_done_o = st_q.cell_pulse;
  assign irq_o = st_q.irq;

endmodule

// File: design/dcsp_pkg.sv
// constants of the channel size and progress-pointer register block
// assumes a byte-addressed register port and one 40 MHz system clock
package dcsp_pkg;

  // ==========================================================
  // widths
  localparam int unsigned DCSP_AW = 8;
  localparam int unsigned DCSP_DW = 32;
  localparam int unsigned DCSP_FW = 16;
  localparam int unsigned DCSP_CW = 17;
  localparam int unsigned DCSP_SW = 3;
  localparam int unsigned DCSP_EW = 4;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] DCSP_OFF_SRC_LEN = 8'h00;
  localparam logic [7:0] DCSP_OFF_DST_LEN = 8'h04;
  localparam logic [7:0] DCSP_OFF_SRC_PROG = 8'h08;
  localparam logic [7:0] DCSP_OFF_DST_PROG = 8'h0C;
  localparam logic [7:0] DCSP_OFF_CELL_LEN = 8'h10;
  localparam logic [7:0] DCSP_OFF_EVT_STS = 8'h14;
  localparam logic [7:0] DCSP_OFF_EVT_MSK = 8'h18;

  // ==========================================================
  // event bit positions in status and mask
  localparam int unsigned DCSP_EV_BLOCK = 0;
  localparam int unsigned DCSP_EV_CELL = 1;
  localparam int unsigned DCSP_EV_SRC_HALF = 2;
  localparam int unsigned DCSP_EV_DST_DONE = 3;

  // ==========================================================
  // values after reset
  localparam logic [15:0] DCSP_RST_LEN = 16'h0000;
  localparam logic [15:0] DCSP_RST_PROG = 16'h0000;
  localparam logic [16:0] DCSP_RST_CNT = 17'h0_0000;
  localparam logic [3:0] DCSP_RST_EVT = 4'h0;
  localparam logic [31:0] DCSP_RST_RDATA = 32'h0000_0000;

  // a zero cell or block length stands for a full 64 KiB
  localparam logic [16:0] DCSP_FULL_LEN = 17'h1_0000;

endpackage

// File: verification/dcsp_regs_chk.sv
// checker of the channel register block, bound to its top module
// assumes ce_i drops only while the ports are quiet, one clock domain
`timescale 1ns/1ps
module dcsp_regs_chk
  import dcsp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [dcsp_pkg::DCSP_AW-1:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [dcsp_pkg::DCSP_DW-1:0] reg_rdata_o,
  // reports and events
  input wire logic [dcsp_pkg::DCSP_SW-1:0] src_bytes_i,
  input wire logic [dcsp_pkg::DCSP_SW-1:0] dst_bytes_i,
  input wire logic pattern_mode_i,
  input wire logic pattern_match_i,
  input wire logic block_done_o,
  input wire logic cell_done_o,
  input wire logic irq_o
);
  // ==========================================================
  // helpers
  logic act;
  assign act = (src_bytes_i != 3'h0) || (dst_bytes_i != 3'h0) || pattern_match_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // properties
  property p_hi; reg_rdata_o[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_idle; !$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_unmap; reg_re_i && reg_addr_i > 8'h18 |=> reg_rdata_o == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_pat; pattern_mode_i && pattern_match_i |=> block_done_o; endproperty
  a_pat: assert property (p_pat) else $error("pattern match gave no block");
  property p_blk; block_done_o |-> $past(act); endproperty
  a_blk: assert property (p_blk) else $error("block pulse without cause");
  property p_cell; cell_done_o |-> $past(dst_bytes_i) != 3'h0; endproperty
  a_cell: assert property (p_cell) else $error("cell pulse without bytes");
  property p_irq_up; $rose(irq_o) |-> $past(act) || $past(reg_we_i); endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
  property p_irq_dn; $fell(irq_o) |-> $past(reg_we_i); endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
endmodule

// File: verification/dcsp_engine_model.sv
// transfer engine stand-in feeding byte reports and pattern events
// assumes the bench calls move between register accesses
`timescale 1ns/1ps
module dcsp_engine_model
(
  // clock
  input wire logic ref_clk_i,
  // reports
  output logic [2:0] src_bytes_o = 3'h0,
  output logic [2:0] dst_bytes_o = 3'h0,
  output logic pattern_mode_o = 1'b0,
  output logic pattern_match_o = 1'b0
);
  // one report cycle, then quiet so no stray bytes get counted
  task automatic move(input logic [2:0] s, input logic [2:0] d, input logic m);
    @(posedge ref_clk_i);
    src_bytes_o <= s;
    dst_bytes_o <= d;
    pattern_mode_o <= m;
    pattern_match_o <= m;
    @(posedge ref_clk_i);
    src_bytes_o <= 3'h0;
    dst_bytes_o <= 3'h0;
    pattern_match_o <= 1'b0;
  endtask
endmodule

// File: verification/tb_dcsp_regs.sv
// self-checking bench of the channel size and progress registers
// assumes the engine model drives the reports, ce_i held high except while t_freeze drops it
`timescale 1ns/1ps
module tb_dcsp_regs;
  import dcsp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdata;
  logic [2:0] sb;
  logic [2:0] db;
  logic pm;
  logic pt;
  logic blk;
  logic cel;
  logic irq;
  int mismatches = 0;
  int checks = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  dcsp_regs u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .src_bytes_i(sb),
    .dst_bytes_i(db), .pattern_mode_i(pm), .pattern_match_i(pt), .block_done_o(blk),
    .cell_done_o(cel), .irq_o(irq));
  dcsp_engine_model u_eng (.ref_clk_i(ref_clk_i), .src_bytes_o(sb), .dst_bytes_o(db),
    .pattern_mode_o(pm), .pattern_match_o(pt));
  // ==========================================================
  // shared tasks
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge ref_clk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge ref_clk_i);
    re <= 1'b0;
    #1;
    ck("rdata", e, rdata);
  endtask
  task automatic mv(input logic [2:0] s, input logic [2:0] d, input logic m);
    u_eng.move(s, d, m);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0000_0000);
    wr(DCSP_OFF_SRC_LEN, 32'hFFFF_FFFF);
    rd(DCSP_OFF_SRC_LEN, 32'h0000_FFFF);
    wr(DCSP_OFF_DST_LEN, 32'hABCD_5A5A);
    rd(DCSP_OFF_DST_LEN, 32'h0000_5A5A);
    wr(DCSP_OFF_DST_LEN, 32'h0000_0000);
    wr(DCSP_OFF_CELL_LEN, 32'h0000_0003);
    rd(DCSP_OFF_CELL_LEN, 32'h0000_0003);
    wr(DCSP_OFF_SRC_PROG, 32'h0000_0055);
    rd(DCSP_OFF_SRC_PROG, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task automatic t_block();
    wr(DCSP_OFF_SRC_LEN, 32'h0000_0004);
    wr(DCSP_OFF_EVT_MSK, 32'h0000_0001);
    mv(3'h2, 3'h0, 1'b0);
    ck("block", 32'h0000_0000, 32'(blk));
    rd(DCSP_OFF_SRC_PROG, 32'h0000_0002);
    rd(DCSP_OFF_EVT_STS, 32'h0000_0004);
    mv(3'h2, 3'h0, 1'b0);
    ck("block", 32'h0000_0001, 32'(blk));
    ck("irq", 32'h0000_0001, 32'(irq));
    rd(DCSP_OFF_SRC_PROG, 32'h0000_0000);
    wr(DCSP_OFF_EVT_MSK, 32'h0000_0000);
    #1;
    ck("irq", 32'h0000_0000, 32'(irq));
    wr(DCSP_OFF_EVT_STS, 32'h0000_000F);
    rd(DCSP_OFF_EVT_STS, 32'h0000_0000);
    $display("t_block done");
  endtask
  task automatic t_dest();
    wr(DCSP_OFF_DST_LEN, 32'h0000_0004);
    mv(3'h0, 3'h3, 1'b0);
    ck("cell", 32'h0000_0001, 32'(cel));
    rd(DCSP_OFF_DST_PROG, 32'h0000_0003);
    mv(3'h0, 3'h1, 1'b0);
    ck("cell", 32'h0000_0000, 32'(cel));
    rd(DCSP_OFF_EVT_STS, 32'h0000_000B);
    rd(DCSP_OFF_DST_PROG, 32'h0000_0000);
    wr(DCSP_OFF_EVT_STS, 32'h0000_000F);
    $display("t_dest done");
  endtask
  task automatic t_pattern();
    mv(3'h1, 3'h0, 1'b0);
    rd(DCSP_OFF_SRC_PROG, 32'h0000_0001);
    mv(3'h0, 3'h0, 1'b1);
    ck("block", 32'h0000_0001, 32'(blk));
    rd(DCSP_OFF_SRC_PROG, 32'h0000_0000);
    $display("t_pattern done");
  endtask
  task automatic t_freeze();
    @(posedge ref_clk_i);
    ce <= 1'b0;
    mv(3'h2, 3'h2, 1'b0);
    @(posedge ref_clk_i);
    ce <= 1'b1;
    rd(DCSP_OFF_SRC_PROG, 32'h0000_0000);
    rd(DCSP_OFF_DST_PROG, 32'h0000_0000);
    $display("t_freeze done");
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_block();
    t_dest();
    t_pattern();
    t_freeze();
    conclude();
  end
  // hang guard, counted as a mismatch
  initial
  begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule
bind dcsp_regs dcsp_regs_chk u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .src_bytes_i(src_bytes_i), .dst_bytes_i(dst_bytes_i), .pattern_mode_i(pattern_mode_i),
  .pattern_match_i(pattern_match_i), .block_done_o(block_done_o), .cell_done_o(cell_done_o),
  .irq_o(irq_o));
